// ---- hw/sls_top.sv ----
// Top of the supply-level control block: pin/register mode selection,
// two-wire serial slave port and an AXI4-Lite register slave.
// Assumes one 125 MHz clock; all pins are asynchronous and synchronised.
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps

// Contract
// RULE1 - Register control off: pins pick level; enable pin low gives 0 V.
// RULE2 - Register control on: level follows register code, even enable low.
// RULE3 - Register control on: register enable bit gates output; resets to 1.
// RULE4 - All registers readable and writable whatever the control bit. Here the status register is read-only; writes to it are ignored.
// RULE5 - Host should set register control when using the serial bus.
// RULE6 - Slave only; same protocol at 100 and 400 kbit/s.
// RULE7 - Only 7-bit addressing; no 10-bit or general call response.
// RULE8 - Strap level selects slave address 0x08, 0x09, 0x10 or 0x11.
// RULE9 - Master sends start, address, register byte, then data byte.
// RULE10 - Each received byte acknowledged by sda low for ninth clock.
// RULE11 - Register updates on falling scl ending the data byte LSB.
// RULE12 - Enable pin low stated to block updates; conflicts with RULE4. The code never lets the enable pin block register writes.
// RULE13 - Master drives scl and start/stop; lines idle high by pull-ups.
// RULE14 - Four-bit code maps 11 V to 20 V in 0.6 V steps.
// RULE15 - Mismatched address leaves sda released; stop returns to idle.
module sls_top #(
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Mode pins and address strap
  input wire logic en_pin,
  input wire logic level_select_pin,
  input wire logic [1:0] strap_level,
  // Supply regulator control
  output logic dish_supply_output,
  output logic [3:0] output_level_code
);
  localparam int IDX_W = 2;
  if (ADDR_W < IDX_W + sls_pkg::IDX_LSB) begin : g_addr_chk
    $error("ADDR_W too small for the register map");
  end

  // Synchronised pins
  logic scl_s, sda_s, en_s, lvl_s;
  logic [1:0] strap_s;
  logic [5:0] pins_s;

  sls_sync #(.WIDTH(6)) u_sync (
    .clk(aclk),
    .rst_n(aresetn),
    .d({scl_in, sda_in, en_pin, level_select_pin, strap_level}),
    .q(pins_s)
  );
  assign {scl_s, sda_s, en_s, lvl_s, strap_s} = pins_s;

  // Strap capture after reset release
  logic [1:0] strap_cnt_q, strap_cnt_d;
  logic [6:0] dev_addr_q, dev_addr_d;

  always_comb begin
    strap_cnt_d = strap_cnt_q;
    dev_addr_d = dev_addr_q;
    if (strap_cnt_q != sls_pkg::STRAP_DONE) begin
      strap_cnt_d = strap_cnt_q + 2'h1;
      case (strap_s) // RULE8
        sls_pkg::STRAP_VCC: dev_addr_d = sls_pkg::ADDR_VCC;
        sls_pkg::STRAP_FLOAT: dev_addr_d = sls_pkg::ADDR_FLOAT;
        sls_pkg::STRAP_GND: dev_addr_d = sls_pkg::ADDR_GND;
        default: dev_addr_d = sls_pkg::ADDR_DIV;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_cnt_q <= '0;
      dev_addr_q <= sls_pkg::ADDR_VCC;
    end else begin
      strap_cnt_q <= strap_cnt_d;
      dev_addr_q <= dev_addr_d;
    end
  end

  // Serial slave engine
  logic i2c_wr, sda_oe_n_i;
  logic [7:0] i2c_ptr, i2c_data, i2c_rd;

  sls_i2c_slave u_i2c ( // RULE6
    .clk(aclk),
    .rst_n(aresetn),
    .scl(scl_s),
    .sda(sda_s),
    .dev_addr(dev_addr_q),
    .rd_data(i2c_rd),
    .sda_oe_n_q(sda_oe_n_i),
    .wr_pulse_q(i2c_wr),
    .ptr_q(i2c_ptr),
    .wr_data_q(i2c_data)
  );
  assign sda_oe_n = sda_oe_n_i;

  // Registers and read mux
  logic [7:0] ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d, status_c;
  logic on_q, on_d;
  logic [3:0] code_q, code_d;

  assign status_c = {3'h0, code_q, on_q};

  function automatic logic [7:0] reg_read(input logic [7:0] idx,
                                         input logic [7:0] c1,
                                         input logic [7:0] c2,
                                         input logic [7:0] st);
    case (idx)
      sls_pkg::REG_CTRL1: reg_read = c1;
      sls_pkg::REG_CTRL2: reg_read = c2;
      sls_pkg::REG_STATUS: reg_read = st;
      default: reg_read = 8'h00;
    endcase
  endfunction

  assign i2c_rd = reg_read(i2c_ptr, ctrl1_q, ctrl2_q, status_c); // RULE4

  // AXI4-Lite slave
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic wlane_q, wlane_d, do_write;
  logic [7:0] aw_idx, ar_idx;

  assign aw_idx = 8'(awaddr_q[ADDR_W-1:sls_pkg::IDX_LSB]);
  assign ar_idx = 8'(araddr[ADDR_W-1:sls_pkg::IDX_LSB]);
  assign do_write = aw_have_q & w_have_q & ~bvalid_q;

  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wbyte_d = wbyte_q;
    wlane_d = wlane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q | ~rvalid_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (awvalid && awready_q) begin
      aw_have_d = 1'b1;
      awaddr_d = awaddr;
    end
    if (wvalid && wready_q) begin
      w_have_d = 1'b1;
      wbyte_d = wdata[7:0];
      wlane_d = wstrb[0];
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (aw_idx < 8'(sls_pkg::REG_COUNT)) ?
                sls_pkg::RESP_OKAY : sls_pkg::RESP_SLVERR;
    end
    awready_d = ~aw_have_d;
    wready_d = ~w_have_d;
    if (arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rdata_d = {24'h0, reg_read(ar_idx, ctrl1_q, ctrl2_q, status_c)};
      rresp_d = (ar_idx < 8'(sls_pkg::REG_COUNT)) ?
                sls_pkg::RESP_OKAY : sls_pkg::RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wbyte_q <= '0;
      wlane_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= sls_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= sls_pkg::RESP_OKAY;
      rdata_q <= '0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wbyte_q <= wbyte_d;
      wlane_q <= wlane_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;

  // Register writes; enable pin level does not block them
  always_comb begin
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    if (do_write && wlane_q) begin
      if (aw_idx == sls_pkg::REG_CTRL1) begin
        ctrl1_d = wbyte_q;
      end else if (aw_idx == sls_pkg::REG_CTRL2) begin
        ctrl2_d = wbyte_q;
      end
    end
    // Serial write wins a same-cycle collision
    if (i2c_wr) begin // RULE4 RULE12
      if (i2c_ptr == sls_pkg::REG_CTRL1) begin
        ctrl1_d = i2c_data;
      end else if (i2c_ptr == sls_pkg::REG_CTRL2) begin
        ctrl2_d = i2c_data;
      end
    end
  end

  // Output mode selection
  always_comb begin
    if (ctrl1_q[sls_pkg::CTRL1_REGCTL_BIT]) begin
      on_d = ctrl2_q[sls_pkg::CTRL2_EN_BIT]; // RULE3
      code_d = ctrl1_q[sls_pkg::CTRL1_LEVEL_LSB +: sls_pkg::LEVEL_W]; // RULE2
    end else begin
      on_d = en_s; // RULE1
      case ({scl_s, lvl_s}) // RULE1
        2'h3: code_d = sls_pkg::LVL_19V4;
        2'h2: code_d = sls_pkg::LVL_14V6;
        2'h1: code_d = sls_pkg::LVL_18V2;
        default: code_d = sls_pkg::LVL_13V4;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1_q <= sls_pkg::CTRL1_RESET;
      ctrl2_q <= sls_pkg::CTRL2_RESET; // RULE3
      on_q <= 1'b0;
      code_q <= sls_pkg::LVL_13V4;
      sda_out <= 1'b0;
    end else begin
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      on_q <= on_d;
      code_q <= code_d;
      sda_out <= 1'b0;
    end
  end

  // Code passes straight to the regulator, 11 V plus 0.6 V per step
  assign output_level_code = code_q; // RULE14
  assign dish_supply_output = on_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_both_taken;
    aw_have_q && w_have_q && !bvalid_q;
  endsequence

  sequence s_read_taken;
    arvalid && arready_q;
  endsequence

  a_pin_mode_off: assert property ( // RULE1
    !ctrl1_q[7] && !en_s |=> !dish_supply_output)
    else $error("pin mode with enable low left output on");

  a_pin_mode_level: assert property ( // RULE1
    !ctrl1_q[7] && en_s && scl_s && lvl_s |=>
      dish_supply_output && output_level_code == sls_pkg::LVL_19V4)
    else $error("pin mode level wrong");

  a_reg_level: assert property ( // RULE2
    ctrl1_q[7] |=> output_level_code == $past(ctrl1_q[4:1]))
    else $error("register level not followed");

  a_reg_enable: assert property ( // RULE3
    ctrl1_q[7] |=> dish_supply_output == $past(ctrl2_q[3]))
    else $error("register enable not followed");

  a_enable_reset: assert property ( // RULE3
    $rose(aresetn) |-> ctrl2_q[3] && !ctrl1_q[7])
    else $error("control reset values wrong");

  a_serial_update: assert property ( // RULE11
    i2c_wr && i2c_ptr == sls_pkg::REG_CTRL2 |=>
      ctrl2_q == $past(i2c_data))
    else $error("serial write did not land");

  a_ack_driven: assert property ( // RULE10
    i2c_wr |-> !sda_oe_n ##1 !sda_oe_n)
    else $error("no ack after data byte");

  a_strap_gnd: assert property ( // RULE8
    strap_cnt_q != 2'h3 && strap_s == 2'h2 |=> dev_addr_q == 7'h10)
    else $error("strap address wrong");

  a_write_answer: assert property (
    s_both_taken |=> bvalid && !$past(awready))
    else $error("write response missing");

  a_read_answer: assert property (
    s_read_taken |=> rvalid ##0 !arready)
    else $error("read response missing");
endmodule

// ---- hw/sls_pkg.sv ----
// Package: constants and types shared by the supply-level control block.
// Assumes one 125 MHz clock; the register map, field, code and address constants live here.
package sls_pkg;

  // Register indices as seen on the two-wire bus
  localparam logic [7:0] REG_CTRL1 = 8'h00;
  localparam logic [7:0] REG_CTRL2 = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  // Register-bus byte address is four times the index
  localparam int REG_COUNT = 3;
  localparam int IDX_LSB = 2;

  // Reset values and field positions
  localparam logic [7:0] CTRL1_RESET = 8'h08;
  localparam logic [7:0] CTRL2_RESET = 8'h09;
  localparam int CTRL1_REGCTL_BIT = 7;
  localparam int CTRL1_LEVEL_LSB = 1;
  localparam int CTRL2_EN_BIT = 3;
  localparam int LEVEL_W = 4;

  // Output level codes chosen by the pins
  localparam logic [3:0] LVL_19V4 = 4'hE;
  localparam logic [3:0] LVL_14V6 = 4'h6;
  localparam logic [3:0] LVL_18V2 = 4'hC;
  localparam logic [3:0] LVL_13V4 = 4'h4;

  // Strap level encodings and resulting slave addresses
  localparam logic [1:0] STRAP_VCC = 2'h0;
  localparam logic [1:0] STRAP_FLOAT = 2'h1;
  localparam logic [1:0] STRAP_GND = 2'h2;
  localparam logic [6:0] ADDR_VCC = 7'h08;
  localparam logic [6:0] ADDR_FLOAT = 7'h09;
  localparam logic [6:0] ADDR_GND = 7'h10;
  localparam logic [6:0] ADDR_DIV = 7'h11;
  localparam logic [1:0] STRAP_DONE = 2'h3;

  // Serial bit counting
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] TX_LAST = 4'h7;

  // Register-bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
    ST_DATA, ST_DATA_ACK, ST_TX, ST_TX_ACK, ST_IGNORE
  } sls_i2c_state_type;

endpackage

// ---- hw/sls_sync.sv ----
// Two-flop synchroniser for pin inputs.
// Assumes inputs are asynchronous to clk; only the second stage is read.
`timescale 1ns/1ps
module sls_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ---- hw/sls_i2c_slave.sv ----
// Write/read slave engine of the two-wire serial port.
// Assumes scl and sda are already synchronised to clk.
`timescale 1ns/1ps
module sls_i2c_slave (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Synchronised bus lines
  input wire logic scl,
  input wire logic sda,
  // Address and read data
  input wire logic [6:0] dev_addr,
  input wire logic [7:0] rd_data,
  // Bus drive, low means pull sda low
  output logic sda_oe_n_q,
  // Register update
  output logic wr_pulse_q,
  output logic [7:0] ptr_q,
  output logic [7:0] wr_data_q
);
  sls_pkg::sls_i2c_state_type state_q, state_d;
  logic scl_q, sda_q, rw_q, rw_d, wr_pulse_d, sda_oe_n_d;
  logic [7:0] sh_q, sh_d, ptr_d, wr_data_d;
  logic [3:0] cnt_q, cnt_d;
  logic scl_rise, scl_fall, start_c, stop_c;

  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign start_c = scl & scl_q & sda_q & ~sda;
  assign stop_c = scl & scl_q & ~sda_q & sda;

  always_comb begin
    state_d = state_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    rw_d = rw_q;
    ptr_d = ptr_q;
    wr_data_d = wr_data_q;
    wr_pulse_d = 1'b0;
    if (stop_c) begin
      state_d = sls_pkg::ST_IDLE; // RULE15
    end else if (start_c) begin
      state_d = sls_pkg::ST_ADDR;
      cnt_d = '0;
    end else begin
      case (state_q)
        sls_pkg::ST_ADDR, sls_pkg::ST_REG, sls_pkg::ST_DATA: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == sls_pkg::BYTE_BITS) begin
            cnt_d = '0;
            if (state_q == sls_pkg::ST_ADDR) begin
              // General call and 10-bit headers never match a strap address
              if (sh_q[7:1] == dev_addr) begin // RULE7
                rw_d = sh_q[0];
                state_d = sls_pkg::ST_ADDR_ACK;
              end else begin
                state_d = sls_pkg::ST_IGNORE; // RULE15
              end
            end else if (state_q == sls_pkg::ST_REG) begin
              ptr_d = sh_q;
              state_d = sls_pkg::ST_REG_ACK;
            end else begin
              wr_data_d = sh_q;
              wr_pulse_d = 1'b1; // RULE11
              state_d = sls_pkg::ST_DATA_ACK;
            end
          end
        end
        sls_pkg::ST_ADDR_ACK: begin
          if (scl_fall && rw_q) begin
            sh_d = rd_data;
            state_d = sls_pkg::ST_TX;
          end else if (scl_fall) begin
            state_d = sls_pkg::ST_REG;
          end
        end
        sls_pkg::ST_REG_ACK, sls_pkg::ST_DATA_ACK: begin
          if (scl_fall) begin
            if (state_q == sls_pkg::ST_DATA_ACK) begin
              ptr_d = ptr_q + 8'h01;
            end
            state_d = sls_pkg::ST_DATA;
          end
        end
        sls_pkg::ST_TX: begin
          if (scl_fall && cnt_q == sls_pkg::TX_LAST) begin
            state_d = sls_pkg::ST_TX_ACK;
          end else if (scl_fall) begin
            sh_d = {sh_q[6:0], 1'b0};
            cnt_d = cnt_q + 4'h1;
          end
        end
        sls_pkg::ST_TX_ACK: begin
          if (scl_rise && sda) begin
            state_d = sls_pkg::ST_IGNORE;
          end else if (scl_rise) begin
            ptr_d = ptr_q + 8'h01;
          end else if (scl_fall) begin
            sh_d = rd_data;
            cnt_d = '0;
            state_d = sls_pkg::ST_TX;
          end
        end
        sls_pkg::ST_IDLE, sls_pkg::ST_IGNORE: begin
          state_d = state_q;
        end
        default: begin
          state_d = sls_pkg::ST_IDLE;
        end
      endcase
    end
    // Ack holds sda low from the falling edge through the ninth clock
    sda_oe_n_d = !(state_d == sls_pkg::ST_ADDR_ACK ||
                   state_d == sls_pkg::ST_REG_ACK ||
                   state_d == sls_pkg::ST_DATA_ACK ||
                   (state_d == sls_pkg::ST_TX && !sh_d[7])); // RULE10
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= sls_pkg::ST_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sh_q <= '0;
      cnt_q <= '0;
      rw_q <= 1'b0;
      ptr_q <= '0;
      wr_data_q <= '0;
      wr_pulse_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else begin
      state_q <= state_d;
      scl_q <= scl;
      sda_q <= sda;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      rw_q <= rw_d;
      ptr_q <= ptr_d;
      wr_data_q <= wr_data_d;
      wr_pulse_q <= wr_pulse_d;
      sda_oe_n_q <= sda_oe_n_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ignore_released: assert property ( // RULE15
    state_q == sls_pkg::ST_IGNORE |-> sda_oe_n_q)
    else $error("sda driven after address mismatch");

  a_stop_to_idle: assert property ( // RULE15
    stop_c |=> state_q == sls_pkg::ST_IDLE && sda_oe_n_q)
    else $error("stop did not return slave to idle");

  a_ack_holds_high: assert property ( // RULE10
    (state_q == sls_pkg::ST_DATA_ACK && scl_rise) |-> !sda_oe_n_q)
    else $error("sda released during ack high phase");
endmodule

// ---- sim/sls_i2c_master.sv ----
// Bus master model that drives the two-wire port of the block.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/1ps
module sls_i2c_master (
  // Clock and resolved data line
  input wire logic clk,
  input wire logic sda,
  // Pull-low requests, high means hold the line low
  output logic scl_low,
  output logic sda_low
);
  // Quarter bit time in clock cycles, 78 gives 400 kbit/s
  int q = 78;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic wt();
    repeat (q) @(posedge clk);
  endtask
  // Start, or repeated start from a low clock
  task automatic start();
    sda_low <= 1'b0;
    wt();
    scl_low <= 1'b0;
    wt();
    sda_low <= 1'b1;
    wt();
    scl_low <= 1'b1;
    wt();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    wt();
    scl_low <= 1'b0;
    wt();
    sda_low <= 1'b0;
    wt();
  endtask
  // One clock pulse; r is high if sda was high at either high-phase sample
  task automatic pulse(input logic b, output logic r);
    logic s;
    sda_low <= !b;
    wt();
    scl_low <= 1'b0;
    wt();
    s = sda;
    wt();
    r = s | sda;
    scl_low <= 1'b1;
    wt();
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      pulse(d[i], r);
    end
    pulse(1'b1, r);
    ack = !r;
  endtask
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      pulse(1'b1, r);
      d[i] = r;
    end
    pulse(last, r);
  endtask
endmodule

// ---- sim/supply_output_i2c_control_bench.sv ----
// Self-checking bench for the supply-level control block.
// Assumes the bus master model is compiled before this file.
`timescale 1ns/1ps
module supply_output_i2c_control_bench;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] awaddr, araddr, wstrb, output_level_code;
  logic [31:0] wdata, rdata;
  logic [1:0] strap_level, bresp, rresp;
  logic en_pin, level_select_pin, dish_supply_output;
  logic awready, wready, bvalid, arready, rvalid, sda_out, sda_oe_n;
  logic scl_low, sda_low;
  wire scl = !scl_low;
  wire sda = (sda_oe_n ? 1'b1 : sda_out) & !sda_low;
  int fails = 0;
  int tests_run = 0;
  logic [6:0] adr [4] = '{7'h08, 7'h09, 7'h10, 7'h11};

  sls_top #(.ADDR_W(4)) dut_u (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid,
    .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid,
    .rready, .rdata, .rresp, .scl_in(scl), .sda_in(sda), .sda_out,
    .sda_oe_n, .en_pin, .level_select_pin, .strap_level,
    .dish_supply_output, .output_level_code);
  sls_i2c_master m_u (.clk(aclk), .sda(sda), .scl_low, .sda_low);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = !aclk;
  end

  task automatic give_verdict();
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cyc(int k);
    repeat (k) @(posedge aclk);
  endtask

  task automatic do_reset(logic [1:0] s);
    @(posedge aclk);
    aresetn <= 1'b0;
    strap_level <= s;
    cyc(4);
    aresetn <= 1'b1;
    cyc(6);
  endtask

  task automatic wr(logic [3:0] a, logic [31:0] d, logic [1:0] er);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bvalid", 1, bvalid);
    chk("bresp", er, bresp);
  endtask

  task automatic rd(logic [3:0] a, logic [31:0] ed, logic [1:0] er);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rvalid", 1, rvalid);
    chk("rdata", ed, rdata);
    chk("rresp", er, rresp);
  endtask

  task automatic iw(logic [6:0] a, logic [7:0] r, logic [7:0] d,
                    logic [2:0] e);
    logic k0, k1, k2;
    m_u.start();
    m_u.put({a, 1'b0}, k0);
    m_u.put(r, k1);
    m_u.put(d, k2);
    m_u.stop();
    chk("ack", e, {k0, k1, k2});
  endtask

  task automatic probe(logic [7:0] b, logic e);
    logic k;
    m_u.start();
    m_u.put(b, k);
    m_u.stop();
    chk("addr ack", e, k);
  endtask

  task automatic t_reset();
    rd(4'h0, 32'h08, 2'h0);
    rd(4'h4, 32'h09, 2'h0);
    chk("supply", 0, dish_supply_output);
    rd(4'hC, 32'h0, 2'h2);
    wr(4'hC, 32'h0, 2'h2);
    wstrb <= 4'hE;
    wr(4'h0, 32'h80, 2'h0);
    wstrb <= 4'hF;
    rd(4'h0, 32'h08, 2'h0);
  endtask

  task automatic t_pins();
    logic [3:0] lv [4] = '{4'h4, 4'hC, 4'h6, 4'hE};
    en_pin <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      m_u.scl_low <= !i[1];
      level_select_pin <= i[0];
      cyc(10);
      chk("code", lv[i], output_level_code);
      chk("supply", 1, dish_supply_output);
    end
    m_u.scl_low <= 1'b0;
    en_pin <= 1'b0;
    cyc(10);
    chk("supply", 0, dish_supply_output);
  endtask

  task automatic t_regctl();
    for (int c = 0; c < 16; c++) begin
      wr(4'h0, 32'h80 | (c << 1), 2'h0);
      cyc(4);
      chk("code", c, output_level_code);
      chk("supply", 1, dish_supply_output);
    end
    wr(4'h4, 32'h01, 2'h0);
    cyc(4);
    chk("supply", 0, dish_supply_output);
    rd(4'h8, 32'h1E, 2'h0);
    wr(4'h4, 32'h09, 2'h0);
    cyc(4);
    chk("supply", 1, dish_supply_output);
  endtask

  task automatic t_addr();
    for (int s = 0; s < 4; s++) begin
      do_reset(s[1:0]);
      probe({adr[s], 1'b0}, 1'b1);
    end
    probe(8'h00, 1'b0);
    probe(8'hF0, 1'b0);
    iw(7'h10, 8'h00, 8'hFF, 3'h0);
    rd(4'h0, 32'h08, 2'h0);
  endtask

  task automatic t_serial();
    logic k;
    logic [7:0] d;
    wr(4'h0, 32'h88, 2'h0);
    m_u.q = 312;
    iw(7'h11, 8'h00, 8'h9A, 3'h7);
    m_u.q = 78;
    cyc(4);
    rd(4'h0, 32'h9A, 2'h0);
    chk("code", 4'hD, output_level_code);
    m_u.start();
    m_u.put({7'h11, 1'b0}, k);
    m_u.put(8'h01, k);
    m_u.start();
    m_u.put({7'h11, 1'b1}, k);
    chk("read ack", 1, k);
    m_u.get(1'b1, d);
    m_u.stop();
    chk("serial data", 8'h09, d);
  endtask

  initial begin
    repeat (95000) @(posedge aclk);
    fails++;
    give_verdict();
  end

  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    strap_level = 2'h0;
    en_pin = 1'b0;
    level_select_pin = 1'b0;
    do_reset(2'h0);
    t_reset();
    t_pins();
    t_regctl();
    t_addr();
    t_serial();
    give_verdict();
  end
endmodule
